// [rtl/panel_image_pkg.sv]
package panel_image_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 32;
	localparam logic [7:0]  IN_BYTE0     = 8'h00;
	localparam logic [7:0]  IN_BYTE1     = 8'h04;
	localparam logic [7:0]  IN_BYTE2     = 8'h08;
	localparam logic [7:0]  IN_BYTE3     = 8'h0C;
	localparam logic [7:0]  IN_BYTE4     = 8'h10;
	localparam logic [7:0]  IN_BYTE5     = 8'h14;
	localparam logic [7:0]  OUT_BYTE0    = 8'h18;
	localparam logic [7:0]  OUT_BYTE1    = 8'h1C;
	localparam logic [7:0]  FKEY_TAGS    = 8'h20;
	localparam logic [7:0]  LIT_TAGS     = 8'h24;
	localparam logic [7:0]  TAG_ENABLE   = 8'h28;
	localparam logic [7:0]  LEFT_STATUS  = 8'h2C;
	localparam logic [7:0]  RIGHT_STATUS = 8'h30;
	localparam logic [7:0]  MODE_CTRL    = 8'h34;
	localparam logic [7:0]  FUNC_GLOBAL  = 8'h38;
	localparam logic [7:0]  FUNC_LOCAL   = 8'h3C;
	localparam logic [7:0]  LOCAL_VALID  = 8'h40;

	// ----------------------------------------------------------------
	// image layout of byte n+1
	// ----------------------------------------------------------------
	localparam int unsigned FKEY9_BIT  = 0;
	localparam int unsigned FKEY10_BIT = 1;
	localparam int unsigned KS_LO_BIT  = 4;
	localparam int unsigned KS_HI_BIT  = 5;
	localparam int unsigned LEFT_BIT   = 6;
	localparam int unsigned RIGHT_BIT  = 7;
	localparam int unsigned FKEYS      = 10;
	localparam int unsigned FUNC_W     = 3;

	localparam logic [1:0] KS_MIDDLE = 2'h0;
	localparam logic [1:0] KS_CW     = 2'h1;
	localparam logic [1:0] KS_CCW    = 2'h2;

	localparam logic [1:0] TAG_OFF  = 2'h0;
	localparam logic [1:0] TAG_FAST = 2'h1;
	localparam logic [1:0] TAG_SLOW = 2'h2;
	localparam logic [1:0] TAG_ON   = 2'h3;

	// ----------------------------------------------------------------
	// flash timing: half periods of the two blink rates
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned FAST_HALF_NS   = 100_000_000;
	localparam int unsigned SLOW_HALF_NS   = 500_000_000;
	localparam int unsigned FAST_HALF_CYC  = FAST_HALF_NS / CLK_PERIOD_NS;
	localparam int unsigned SLOW_HALF_CYC  = SLOW_HALF_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		MODE_OFFLINE = 2'b00,
		MODE_ONLINE  = 2'b01,
		MODE_LOAD    = 2'b10
	} device_mode_type;
	localparam device_mode_type MODE_RESET = MODE_OFFLINE;

	typedef struct packed {
		logic [FKEYS-1:0] function_keys;
		logic             keyswitch_cw;
		logic             keyswitch_ccw;
		logic             left_lit_pushbutton;
		logic             right_lit_pushbutton;
	} panel_controls_type;

	typedef struct packed {
		logic [FKEYS-1:0] function_key_lamp;
		logic             left_lamp;
		logic             right_lamp;
	} panel_lamps_type;

endpackage

// [rtl/panel_image.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module panel_image
	import panel_image_pkg::*;
#(
	parameter bit          LARGE_VARIANT = 1'b1,
	parameter int unsigned FAST_CYCLES   = FAST_HALF_CYC,
	parameter int unsigned SLOW_CYCLES   = SLOW_HALF_CYC
)(
	input  wire logic               clk,             // 125 MHz clock
	input  wire logic               rstn,            // synchronous reset, low
	input  wire panel_controls_type controls,        // raw key, switch and button levels
	input  wire logic [23:0]        touch_keys,      // touch direct keys 8..31
	input  wire logic               project_running, // a project is running
	input  wire logic               box_attached,    // panel sits on a connection box
	input  wire logic [ADDR_W-1:0]  addr,            // register address
	input  wire logic [DATA_W-1:0]  wdata,           // write data
	input  wire logic               wr,              // write strobe
	input  wire logic               rd,              // read strobe
	output      logic [DATA_W-1:0]  rdata,           // read data, cycle after rd
	output      panel_lamps_type    lamps,           // lamp drive levels
	output      device_mode_type    device_mode,     // current operating mode
	output      logic               function_fire,   // pulse: key pressed
	output      logic [FUNC_W-1:0]  function_code    // function of that key
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic lamp_decode(input logic [1:0] tag, input logic fast, input logic slow);
		case (tag)
			TAG_OFF:  lamp_decode = 1'b0;
			TAG_FAST: lamp_decode = fast;
			TAG_SLOW: lamp_decode = slow;
			default:  lamp_decode = 1'b1;
		endcase
	endfunction

	function automatic logic [1:0] keyswitch_code(input logic cw, input logic ccw);
		// both contacts at once is impossible mechanically; report middle
		if (cw && !ccw)
			keyswitch_code = KS_CW;
		else if (ccw && !cw)
			keyswitch_code = KS_CCW;
		else
			keyswitch_code = KS_MIDDLE;
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]             in_byte_reg [6];
	logic [7:0]             out0_reg;
	logic [7:0]             out1_reg;
	logic [2*FKEYS-1:0]     fkey_tags_reg;
	logic [3:0]             lit_tags_reg;
	logic [FKEYS+1:0]       tag_enable_reg;
	logic [FKEYS*FUNC_W-1:0] func_global_reg;
	logic [FKEYS*FUNC_W-1:0] func_local_reg;
	logic [FKEYS-1:0]       local_valid_reg;
	logic [FKEYS-1:0]       press_prev_reg;
	logic [DATA_W-1:0]      rdata_reg;
	panel_lamps_type        lamps_reg;
	panel_lamps_type        lamps_next;
	device_mode_type        mode_reg;
	device_mode_type        mode_next;
	logic                   fire_reg;
	logic [FUNC_W-1:0]      code_reg;
	logic [31:0]            fast_cnt_reg;
	logic [31:0]            slow_cnt_reg;
	logic                   fast_reg;
	logic                   slow_reg;
	logic [FKEYS-1:0]       keys_now;
	logic [FKEYS-1:0]       new_press;
	logic [FKEYS-1:0]       direct_bits;

	assign direct_bits = {out1_reg[FKEY10_BIT], out1_reg[FKEY9_BIT], out0_reg};

	assign rdata         = rdata_reg;
	assign lamps         = lamps_reg;
	assign device_mode   = mode_reg;
	assign function_fire = fire_reg;
	assign function_code = code_reg;

	// ----------------------------------------------------------------
	// input image
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 6; i++)
				in_byte_reg[i] <= 8'h00;
		end
		else
		begin
			in_byte_reg[0] <= project_running ? controls.function_keys[7:0] : 8'h00;
			in_byte_reg[1] <= 8'h00;
			if (box_attached)
			begin
				in_byte_reg[1][RIGHT_BIT] <= controls.right_lit_pushbutton;
				in_byte_reg[1][LEFT_BIT]  <= controls.left_lit_pushbutton;
				in_byte_reg[1][KS_HI_BIT:KS_LO_BIT] <=
					keyswitch_code(controls.keyswitch_cw, controls.keyswitch_ccw);
			end
			if (LARGE_VARIANT && project_running)
			begin
				in_byte_reg[1][FKEY9_BIT]  <= controls.function_keys[8];
				in_byte_reg[1][FKEY10_BIT] <= controls.function_keys[9];
			end
			// byte n+2 would hold keys 0..7, which this panel does not have
			in_byte_reg[2] <= 8'h00;
			for (int i = 0; i < 3; i++)
				in_byte_reg[3+i] <= touch_keys[8*i +: 8];
		end
	end

	// ----------------------------------------------------------------
	// register write port
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			out0_reg        <= 8'h00;
			out1_reg        <= 8'h00;
			fkey_tags_reg   <= '0;
			lit_tags_reg    <= 4'h0;
			tag_enable_reg  <= '0;
			func_global_reg <= '0;
			func_local_reg  <= '0;
			local_valid_reg <= '0;
		end
		else if (wr)
		begin
			case (addr)
				OUT_BYTE0:   out0_reg        <= wdata[7:0];
				OUT_BYTE1:   out1_reg        <= wdata[7:0];
				FKEY_TAGS:   fkey_tags_reg   <= wdata[2*FKEYS-1:0];
				LIT_TAGS:    lit_tags_reg    <= wdata[3:0];
				TAG_ENABLE:  tag_enable_reg  <= wdata[FKEYS+1:0];
				FUNC_GLOBAL: func_global_reg <= wdata[FKEYS*FUNC_W-1:0];
				FUNC_LOCAL:  func_local_reg  <= wdata[FKEYS*FUNC_W-1:0];
				LOCAL_VALID: local_valid_reg <= wdata[FKEYS-1:0];
				default:     ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// operating mode
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_next = mode_reg;
		if (wr && addr == MODE_CTRL)
		begin
			case (wdata[1:0])
				MODE_OFFLINE: mode_next = MODE_OFFLINE;
				MODE_ONLINE:  mode_next = MODE_ONLINE;
				MODE_LOAD:    mode_next = MODE_LOAD;
				default:      mode_next = mode_reg;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			mode_reg <= MODE_RESET;
		else
			mode_reg <= mode_next;
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata_reg <= '0;
		else if (rd)
		begin
			case (addr)
				IN_BYTE0:     rdata_reg <= {24'h000000, in_byte_reg[0]};
				IN_BYTE1:     rdata_reg <= {24'h000000, in_byte_reg[1]};
				IN_BYTE2:     rdata_reg <= {24'h000000, in_byte_reg[2]};
				IN_BYTE3:     rdata_reg <= {24'h000000, in_byte_reg[3]};
				IN_BYTE4:     rdata_reg <= {24'h000000, in_byte_reg[4]};
				IN_BYTE5:     rdata_reg <= {24'h000000, in_byte_reg[5]};
				OUT_BYTE0:    rdata_reg <= {24'h000000, out0_reg};
				OUT_BYTE1:    rdata_reg <= {24'h000000, out1_reg};
				FKEY_TAGS:    rdata_reg <= {12'h000, fkey_tags_reg};
				LIT_TAGS:     rdata_reg <= {28'h0000000, lit_tags_reg};
				TAG_ENABLE:   rdata_reg <= {20'h00000, tag_enable_reg};
				LEFT_STATUS:  rdata_reg <= {31'h00000000, in_byte_reg[1][LEFT_BIT]};
				RIGHT_STATUS: rdata_reg <= {31'h00000000, in_byte_reg[1][RIGHT_BIT]};
				MODE_CTRL:    rdata_reg <= {30'h00000000, mode_reg};
				FUNC_GLOBAL:  rdata_reg <= {2'h0, func_global_reg};
				FUNC_LOCAL:   rdata_reg <= {2'h0, func_local_reg};
				LOCAL_VALID:  rdata_reg <= {22'h000000, local_valid_reg};
				default:      rdata_reg <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flash dividers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			fast_cnt_reg <= '0;
			fast_reg     <= 1'b0;
		end
		else if (fast_cnt_reg == FAST_CYCLES - 1)
		begin
			fast_cnt_reg <= '0;
			fast_reg     <= ~fast_reg;
		end
		else
			fast_cnt_reg <= fast_cnt_reg + 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			slow_cnt_reg <= '0;
			slow_reg     <= 1'b0;
		end
		else if (slow_cnt_reg == SLOW_CYCLES - 1)
		begin
			slow_cnt_reg <= '0;
			slow_reg     <= ~slow_reg;
		end
		else
			slow_cnt_reg <= slow_cnt_reg + 32'h1;
	end

	// ----------------------------------------------------------------
	// lamp drive: direct image bit, or two-bit tag where enabled
	// ----------------------------------------------------------------
	always_comb
	begin
		lamps_next = '0;
		for (int i = 0; i < FKEYS; i++)
		begin
			if (i >= 8 && !LARGE_VARIANT)
				lamps_next.function_key_lamp[i] = 1'b0;
			else if (!project_running)
				lamps_next.function_key_lamp[i] = 1'b0;
			else if (tag_enable_reg[i])
				lamps_next.function_key_lamp[i] = lamp_decode(fkey_tags_reg[2*i +: 2], fast_reg, slow_reg);
			else
				lamps_next.function_key_lamp[i] = direct_bits[i];
		end
		if (box_attached)
		begin
			lamps_next.left_lamp  = tag_enable_reg[FKEYS] ?
				lamp_decode(lit_tags_reg[1:0], fast_reg, slow_reg) : out1_reg[LEFT_BIT];
			lamps_next.right_lamp = tag_enable_reg[FKEYS+1] ?
				lamp_decode(lit_tags_reg[3:2], fast_reg, slow_reg) : out1_reg[RIGHT_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			lamps_reg <= '0;
		else
			lamps_reg <= lamps_next;
	end

	// ----------------------------------------------------------------
	// function dispatch on a new key press
	// ----------------------------------------------------------------
	assign keys_now  = {in_byte_reg[1][FKEY10_BIT], in_byte_reg[1][FKEY9_BIT], in_byte_reg[0]};
	assign new_press = keys_now & ~press_prev_reg;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			press_prev_reg <= '0;
			fire_reg       <= 1'b0;
			code_reg       <= '0;
		end
		else
		begin
			press_prev_reg <= keys_now;
			fire_reg       <= |new_press;
			// lowest key wins when several go down in one cycle
			for (int i = FKEYS - 1; i >= 0; i--)
			begin
				if (new_press[i])
					code_reg <= local_valid_reg[i] ? func_local_reg[FUNC_W*i +: FUNC_W]
					                               : func_global_reg[FUNC_W*i +: FUNC_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence mode_req_load;
		wr && addr == MODE_CTRL && wdata[1:0] == MODE_LOAD;
	endsequence
	sequence mode_is_load;
		mode_reg == MODE_LOAD;
	endsequence

	keyswitch_legal_a: assert property (in_byte_reg[1][KS_HI_BIT:KS_LO_BIT] != 2'h3)
		else $error("keyswitch code 11 reported");
	fkey_gated_a: assert property (!project_running |=> in_byte_reg[0] == 8'h00)
		else $error("function keys reported without project");
	fkey_follow_a: assert property (project_running |=> in_byte_reg[0] == $past(controls.function_keys[7:0]))
		else $error("function key byte wrong");
	left_button_a: assert property (box_attached |=> in_byte_reg[1][LEFT_BIT] == $past(controls.left_lit_pushbutton))
		else $error("left button bit wrong");
	touch_map_a: assert property (##1 in_byte_reg[5] == $past(touch_keys[23:16]))
		else $error("touch byte n+5 wrong");
	steady_tag_a: assert property (project_running && tag_enable_reg[2] && fkey_tags_reg[5:4] == TAG_ON
		|=> lamps_reg.function_key_lamp[2])
		else $error("steady tag not lit");
	off_lamp_a: assert property (!box_attached |=> !lamps_reg.left_lamp && !lamps_reg.right_lamp)
		else $error("lit button lamp without box");
	mode_load_a: assert property (mode_req_load |=> mode_is_load)
		else $error("load mode not entered");
	local_first_a: assert property (new_press[0] && local_valid_reg[0]
		|=> function_fire && function_code == $past(func_local_reg[FUNC_W-1:0]))
		else $error("local function not preferred");

endmodule // panel_image

// [tb/plc_bus_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// controller side: reads and writes the process image words
// ----------------------------------------------------------------
module plc_bus_model
	import panel_image_pkg::*;
(
	input  wire logic              clk,   // bus clock
	output      logic [ADDR_W-1:0] addr,  // register byte address
	output      logic [DATA_W-1:0] wdata, // write data
	output      logic              wr,    // write strobe
	output      logic              rd,    // read strobe
	input  wire logic [DATA_W-1:0] rdata  // read data, one cycle after rd
);
	int gap = 0;

	initial
	begin
		addr  = '0;
		wdata = '0;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// released lines show the inverse so a stale value never looks valid
	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
	endtask

	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask
endmodule // plc_bus_model

// [tb/panel_image_test.sv]
`timescale 1ns/10ps
module panel_image_test;
	import panel_image_pkg::*;
	localparam int unsigned FAST = 4;
	localparam int unsigned SLOW = 10;

	logic               clk;
	logic               rstn;
	panel_controls_type controls;
	logic [23:0]        touch_keys;
	logic               project_running;
	logic               box_attached;
	logic [ADDR_W-1:0]  addr;
	logic [DATA_W-1:0]  wdata;
	logic [DATA_W-1:0]  rdata;
	logic               wr;
	logic               rd;
	panel_lamps_type    lamps;
	device_mode_type    device_mode;
	logic               function_fire;
	logic [FUNC_W-1:0]  function_code;
	int                 miscompares = 0;
	int                 n_tests = 0;
	int                 cycles = 0;
	integer             seed = 32'h908620C3;
	int                 fk, cw, ccw, lb, rb, run, box, touch;
	logic [DATA_W-1:0]  d;
	logic [DATA_W-1:0]  w;

	panel_image #(.LARGE_VARIANT(1'b1), .FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) u_panel_image (
		.clk(clk), .rstn(rstn), .controls(controls), .touch_keys(touch_keys),
		.project_running(project_running), .box_attached(box_attached), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .lamps(lamps), .device_mode(device_mode),
		.function_fire(function_fire), .function_code(function_code));

	plc_bus_model u_plc_bus_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
		n_tests++;
		if (seen !== expected)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, expected, seen);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			test_done();
		end
	end

	task automatic drive();
		@(posedge clk);
		controls.function_keys        <= fk[9:0];
		controls.keyswitch_cw         <= cw[0];
		controls.keyswitch_ccw        <= ccw[0];
		controls.left_lit_pushbutton  <= lb[0];
		controls.right_lit_pushbutton <= rb[0];
		touch_keys                    <= touch[23:0];
		project_running               <= run[0];
		box_attached                  <= box[0];
	endtask

	// ----------------------------------------------------------------
	// reference image bytes n and n+1
	// ----------------------------------------------------------------
	function automatic int exp_in(input int i);
		int ks;
		ks = (cw && !ccw) ? 1 : (ccw && !cw) ? 2 : 0;
		if (i == 0)
			return run ? (fk & 255) : 0;
		return (box ? (rb << 7 | lb << 6 | ks << 4) : 0) | (run ? ((fk >> 8) & 3) : 0);
	endfunction

	initial
	begin
		int nf, ns, nr, on_all, off_any, k, o0, o1;
		logic p0, p1, pr;
		device_mode_type modes [4];
		device_mode_type want [4];
		controls        = '0;
		touch_keys      = '0;
		project_running = 1'b0;
		box_attached    = 1'b0;
		rstn            = 1'b0;
		{fk, cw, ccw, lb, rb, run, box, touch} = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		check("reset lamps", lamps, 0);
		check("reset mode", device_mode, MODE_RESET);
		// ----------------------------------------------------------------
		// input image under random controls, gating and bus spacing
		// ----------------------------------------------------------------
		for (int t = 0; t < 24; t++)
		begin
			fk    = $random(seed) & 1023;
			cw    = $random(seed) & 1;
			ccw   = $random(seed) & 1;
			lb    = $random(seed) & 1;
			rb    = $random(seed) & 1;
			touch = $random(seed) & 24'hFFFFFF;
			run   = (t % 4) != 0;
			box   = (t % 5) != 1;
			u_plc_bus_model.gap = t % 3;
			drive();
			repeat (2) @(posedge clk);
			for (int i = 0; i < 2; i++)
			begin
				u_plc_bus_model.read_reg(IN_BYTE0 + 8'(4 * i), d);
				check("input byte", d, exp_in(i));
			end
			for (int i = 0; i < 4; i++)
			begin
				u_plc_bus_model.read_reg(IN_BYTE2 + 8'(4 * i), d);
				w[8 * i +: 8] = d[7:0];
			end
			check("touch bytes", w, {touch[23:0], 8'h00});
		end
		u_plc_bus_model.gap = 0;
		u_plc_bus_model.read_reg(8'h44, d);
		check("unmapped", d, 0);
		// ----------------------------------------------------------------
		// direct lamp bits from the output image
		// ----------------------------------------------------------------
		for (int t = 0; t < 8; t++)
		begin
			o0  = $random(seed) & 255;
			o1  = $random(seed) & 8'hC3;
			run = t % 3 != 0;
			box = t % 4 != 1;
			drive();
			u_plc_bus_model.write_reg(TAG_ENABLE, 0);
			u_plc_bus_model.write_reg(OUT_BYTE0, o0);
			u_plc_bus_model.write_reg(OUT_BYTE1, o1);
			repeat (3) @(posedge clk);
			#1;
			check("lamps", lamps, {run ? 10'(o1 << 8 | o0) : 10'h0, 1'(box & o1 >> 6), 1'(box & o1 >> 7)});
			u_plc_bus_model.read_reg(OUT_BYTE1, d);
			check("output byte", d, o1);
		end
		lb = 1;
		rb = 0;
		drive();
		repeat (2) @(posedge clk);
		u_plc_bus_model.read_reg(LEFT_STATUS, d);
		check("left status", d, 1);
		u_plc_bus_model.read_reg(RIGHT_STATUS, d);
		check("right status", d, 0);
		// ----------------------------------------------------------------
		// tag driven lamps: fast, slow, steady, off
		// ----------------------------------------------------------------
		run = 1;
		box = 1;
		drive();
		u_plc_bus_model.write_reg(FKEY_TAGS, 32'h39);
		u_plc_bus_model.write_reg(LIT_TAGS, 32'h7);
		u_plc_bus_model.write_reg(TAG_ENABLE, 32'hC0F);
		repeat (3) @(posedge clk);
		#1;
		nf      = 0;
		ns      = 0;
		nr      = 0;
		on_all  = 1;
		off_any = 0;
		{p0, p1, pr} = {lamps.function_key_lamp[0], lamps.function_key_lamp[1], lamps.right_lamp};
		repeat (100)
		begin
			@(posedge clk);
			#1;
			nf += (lamps.function_key_lamp[0] !== p0);
			ns += (lamps.function_key_lamp[1] !== p1);
			nr += (lamps.right_lamp !== pr);
			on_all &= (lamps.function_key_lamp[2] === 1'b1) && (lamps.left_lamp === 1'b1);
			off_any |= (lamps.function_key_lamp[3] !== 1'b0);
			{p0, p1, pr} = {lamps.function_key_lamp[0], lamps.function_key_lamp[1], lamps.right_lamp};
		end
		check("fast toggles", nf inside {[23:26]}, 1);
		check("slow toggles", ns inside {[9:11]}, 1);
		check("fast button", nr inside {[23:26]}, 1);
		check("steady on", on_all, 1);
		check("off", off_any, 0);
		// ----------------------------------------------------------------
		// operating modes; code 11 leaves the mode alone
		// ----------------------------------------------------------------
		modes = '{MODE_ONLINE, MODE_LOAD, device_mode_type'(2'h3), MODE_OFFLINE};
		want  = '{MODE_ONLINE, MODE_LOAD, MODE_LOAD, MODE_OFFLINE};
		for (int i = 0; i < 4; i++)
		begin
			u_plc_bus_model.write_reg(MODE_CTRL, modes[i]);
			@(posedge clk);
			#1;
			check("mode", device_mode, want[i]);
			u_plc_bus_model.read_reg(MODE_CTRL, d);
			check("mode read", d, want[i]);
		end
		// ----------------------------------------------------------------
		// key functions: global, then local override
		// ----------------------------------------------------------------
		fk = 0;
		drive();
		u_plc_bus_model.write_reg(FUNC_GLOBAL, 32'h35);
		u_plc_bus_model.write_reg(FUNC_LOCAL, 32'h2);
		for (int v = 0; v < 2; v++)
		begin
			u_plc_bus_model.write_reg(LOCAL_VALID, v);
			repeat (2) @(posedge clk);
			fk = 3;
			drive();
			k = 0;
			do
			begin
				@(posedge clk);
				#1;
				k++;
			end
			while (function_fire !== 1'b1 && k < 6);
			check("fire", function_fire, 1);
			check("code", function_code, v ? 2 : 5);
			@(posedge clk);
			#1;
			check("fire pulse", function_fire, 0);
			fk = 0;
			drive();
		end
		test_done();
	end
endmodule // panel_image_test
